/* File: hdl/trip_params.svh */
// Constants for the trip supervisor: register offsets, reset values,
// trip codes, link modes and timing counts.
// Assumes a single 10 MHz system clock.
`ifndef TRIP_PARAMS_SVH
`define TRIP_PARAMS_SVH

`define ADDR_W              4
`define REG_IGAIN           4'h0
`define REG_DCBUS           4'h1
`define REG_FAULT           4'h2
`define REG_LIMIT           4'h3
`define REG_DELAY           4'h4
`define REG_MODE            4'h5
`define REG_OVL_LEVEL       4'h6
`define REG_RATED           4'h7
`define REG_POINTER         4'h8
`define REG_STATUS          4'h9
`define REG_OVL_CFG         4'ha

`define RST_IGAIN           16'h0000
`define RST_DCBUS           16'h0000
`define RST_FAULT           8'h00
`define RST_LIMIT           3'h0
`define RST_DELAY           8'h0a
`define RST_MODE            2'h1
`define RST_RATED           16'h0064
`define RST_POINTER         16'h0000
`define LIMIT_MAX           3'h5
`define DELAY_MAX           8'hfa
`define STATUS_CLEAR_BIT    0

// Trip code values are arbitrary
`define CODE_EXTERNAL_FAULT_TRIP           8'h06
`define CODE_OUTPUT_STAGE_OVERCURRENT_TRIP 8'h03
`define CODE_BRAKING_STAGE_OVERCURRENT_TRIP 8'h04
`define CODE_OVERLOAD_TIME_TRIP            8'h14

`define MODE_TWO_WIRE       2'h0
`define MODE_FOUR_WIRE      2'h1
`define MODE_PARAM_OUT      2'h2
`define MODE_PARAM_IN       2'h3

`define SYS_CLK_HZ          10000000
`define TICK_MS             100
`define TICK_CYCLES         (`SYS_CLK_HZ / 1000 * `TICK_MS)
`define QUIET_MIN           5
`define QUIET_TICKS         (`QUIET_MIN * 60 * 1000 / `TICK_MS)
`define OC_HOLD_S           10
`define OC_HOLD_TICKS       (`OC_HOLD_S * 1000 / `TICK_MS)
`define OVL_FULL            7'h64
`define OVL_NUM             21'h000015
`define OVL_DEN             21'h000014

`endif

/* File: hdl/trip_pkg.sv */
// Types shared by the trip supervisor.
// Numbers live in trip_params.svh.
package trip_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_WAIT   = 2'b01,
		ST_LOCKED = 2'b10
	} reset_state_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} trip_evt_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} link_word_t;

endpackage : trip_pkg

/* File: hdl/trip_supervisor.sv */
// Fault supervision: last-trip log, auto-reset sequencer, overload
// accumulator and serial-link mode selection with a register port.
// Assumes trip_valid_in, current and link inputs share sys_clk_in;
// only the external trip pin is asynchronous.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "trip_params.svh"

// Notes on behaviour
// - Every trip logs its code as last fault, unless a higher-ranked trip arrives in the same cycle
// - Last fault holds until a differing trip or a write to the fault register
// - Attempt limit zero disables auto reset
// - Nonzero limit auto-resets trips that many times
// - Same code increments count, different clears it
// - Count at limit blocks further same resets
// - Five quiet minutes clear the reset count
// - External trips never auto-reset
// - Programmable delay before auto reset
// - Over-current trips hold at least ten seconds
// - Mode 0 two-wire, mode 1 four-wire default
// - Mode 2 transmits the pointed parameter value
// - Mode 3 writes received value to pointed parameter
// - Accumulator rises only above 105 percent current
// - Full accumulator trips or restricts current limit
// - Changing rated current clears the accumulator
module trip_supervisor #(
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic              sys_clk_in,
	input  wire logic              nrst_in,
	input  wire logic [`ADDR_W-1:0] reg_addr_in,
	input  wire logic [15:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [15:0]       reg_rdata_out,
	input  wire logic              trip_valid_in,
	input  wire logic [7:0]        trip_code_in,
	input  wire logic              ext_trip_pin_in,
	input  wire logic [15:0]       total_current_in,
	input  wire logic [15:0]       param_value_in,
	input  wire logic              link_tx_ready_in,
	input  wire logic              link_rx_valid_in,
	input  wire logic [15:0]       link_rx_data_in,
	output logic                   trip_active_out,
	output logic                   auto_reset_out,
	output logic                   overload_trip_out,
	output logic                   current_limit_restrict_out,
	output logic                   link_four_wire_out,
	output logic                   link_tx_valid_out,
	output logic      [15:0]       link_tx_data_out,
	output logic                   param_wr_out,
	output logic      [15:0]       param_sel_out,
	output logic      [15:0]       param_wdata_out
);

	// ==========================================================
	// Reset release and tick
	logic        rst_s1_r;
	logic        rst_n;
	logic [19:0] tick_cnt_r;
	logic [19:0] tick_cnt_nxt;
	logic        tick_r;
	logic        tick_nxt;

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_s1_r <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n    <= rst_s1_r;
		end
	end

	// One tick per 100 ms keeps every long timer narrow
	always_comb begin
		tick_nxt     = 1'b0;
		tick_cnt_nxt = tick_cnt_r + 20'h00001;
		if (tick_cnt_r >= 20'(TICK_CYCLES - 1)) begin
			tick_cnt_nxt = 20'h00000;
			tick_nxt     = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 20'h00000;
			tick_r     <= 1'b0;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			tick_r     <= tick_nxt;
		end
	end

	// ==========================================================
	// External trip pin
	logic ext_s1_r;
	logic ext_s2_r;
	logic ext_s3_r;
	logic ext_lvl_r;
	logic ext_lvl_nxt;
	logic ext_rise;

	always_comb begin
		ext_lvl_nxt = (ext_s2_r == ext_s3_r) ? ext_s3_r : ext_lvl_r;
		ext_rise    = ext_lvl_nxt && !ext_lvl_r;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ext_s1_r  <= 1'b0;
			ext_s2_r  <= 1'b0;
			ext_s3_r  <= 1'b0;
			ext_lvl_r <= 1'b0;
		end else begin
			ext_s1_r  <= ext_trip_pin_in;
			ext_s2_r  <= ext_s1_r;
			ext_s3_r  <= ext_s2_r;
			ext_lvl_r <= ext_lvl_nxt;
		end
	end

	// ==========================================================
	// Register file
	logic [15:0] igain_r, igain_nxt;
	logic [15:0] dcbus_r, dcbus_nxt;
	logic [2:0]  limit_r, limit_nxt;
	logic [7:0]  delay_r, delay_nxt;
	logic [1:0]  mode_r, mode_nxt;
	logic [15:0] rated_r, rated_nxt;
	logic [15:0] ptr_r, ptr_nxt;
	logic        ovl_cfg_r, ovl_cfg_nxt;
	logic [15:0] rdata_nxt;
	logic        rated_change;
	logic        sw_clear;
	logic        fault_wr;
	logic [7:0]  last_fault_r;
	logic [6:0]  acc_r;
	logic [2:0]  cnt_r;
	trip_pkg::reset_state_t state_r;

	function automatic logic is_wr(input logic [`ADDR_W-1:0] a);
		is_wr = reg_wr_in && (reg_addr_in == a);
	endfunction : is_wr

	always_comb begin
		igain_nxt    = igain_r;
		dcbus_nxt    = dcbus_r;
		limit_nxt    = limit_r;
		delay_nxt    = delay_r;
		mode_nxt     = mode_r;
		rated_nxt    = rated_r;
		ptr_nxt      = ptr_r;
		ovl_cfg_nxt  = ovl_cfg_r;
		rated_change = is_wr(`REG_RATED) && (reg_wdata_in != rated_r);
		sw_clear     = is_wr(`REG_STATUS) && reg_wdata_in[`STATUS_CLEAR_BIT];
		fault_wr     = is_wr(`REG_FAULT);
		if (is_wr(`REG_IGAIN)) begin
			igain_nxt = reg_wdata_in;
		end else if (is_wr(`REG_DCBUS)) begin
			dcbus_nxt = reg_wdata_in;
		end else if (is_wr(`REG_LIMIT)) begin
			// Out-of-range settings clamp to the top of the range
			limit_nxt = (reg_wdata_in > 16'(`LIMIT_MAX)) ?
				`LIMIT_MAX : reg_wdata_in[2:0];
		end else if (is_wr(`REG_DELAY)) begin
			delay_nxt = (reg_wdata_in > 16'(`DELAY_MAX)) ?
				`DELAY_MAX : reg_wdata_in[7:0];
		end else if (is_wr(`REG_MODE)) begin
			mode_nxt = reg_wdata_in[1:0];
		end else if (is_wr(`REG_RATED)) begin
			rated_nxt = reg_wdata_in;
		end else if (is_wr(`REG_POINTER)) begin
			ptr_nxt = reg_wdata_in;
		end else if (is_wr(`REG_OVL_CFG)) begin
			ovl_cfg_nxt = reg_wdata_in[0];
		end
		rdata_nxt = 16'h0000;
		if (!reg_rd_in) begin
			rdata_nxt = 16'h0000;
		end else if (reg_addr_in == `REG_IGAIN) begin
			rdata_nxt = igain_r;
		end else if (reg_addr_in == `REG_DCBUS) begin
			rdata_nxt = dcbus_r;
		end else if (reg_addr_in == `REG_FAULT) begin
			rdata_nxt = {8'h00, last_fault_r};
		end else if (reg_addr_in == `REG_LIMIT) begin
			rdata_nxt = {13'h0000, limit_r};
		end else if (reg_addr_in == `REG_DELAY) begin
			rdata_nxt = {8'h00, delay_r};
		end else if (reg_addr_in == `REG_MODE) begin
			rdata_nxt = {14'h0000, mode_r};
		end else if (reg_addr_in == `REG_OVL_LEVEL) begin
			rdata_nxt = {9'h000, acc_r};
		end else if (reg_addr_in == `REG_RATED) begin
			rdata_nxt = rated_r;
		end else if (reg_addr_in == `REG_POINTER) begin
			rdata_nxt = ptr_r;
		end else if (reg_addr_in == `REG_STATUS) begin
			rdata_nxt = {8'h00, current_limit_restrict_out,
				overload_trip_out, cnt_r, state_r, trip_active_out};
		end else if (reg_addr_in == `REG_OVL_CFG) begin
			rdata_nxt = {15'h0000, ovl_cfg_r};
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			igain_r       <= `RST_IGAIN;
			dcbus_r       <= `RST_DCBUS;
			limit_r       <= `RST_LIMIT;
			delay_r       <= `RST_DELAY;
			mode_r        <= `RST_MODE;
			rated_r       <= `RST_RATED;
			ptr_r         <= `RST_POINTER;
			ovl_cfg_r     <= 1'b0;
			reg_rdata_out <= 16'h0000;
		end else begin
			igain_r       <= igain_nxt;
			dcbus_r       <= dcbus_nxt;
			limit_r       <= limit_nxt;
			delay_r       <= delay_nxt;
			mode_r        <= mode_nxt;
			rated_r       <= rated_nxt;
			ptr_r         <= ptr_nxt;
			ovl_cfg_r     <= ovl_cfg_nxt;
			reg_rdata_out <= rdata_nxt;
		end
	end

	// ==========================================================
	// Overload accumulator
	logic [6:0]  acc_nxt;
	logic [20:0] cur_scaled;
	logic [20:0] lim_scaled;
	logic        over;
	logic        ovl_trip_nxt;
	logic        restrict_nxt;
	logic        ovl_evt;

	always_comb begin
		cur_scaled = 21'(total_current_in) * `OVL_DEN;
		lim_scaled = 21'(rated_r) * `OVL_NUM;
		over       = cur_scaled > lim_scaled;
		acc_nxt    = acc_r;
		if (rated_change) begin
			acc_nxt = 7'h00;
		end else if (tick_r && over && acc_r < `OVL_FULL) begin
			acc_nxt = acc_r + 7'h01;
		end else if (tick_r && !over && acc_r != 7'h00) begin
			// Cools down one step per tick at or below the threshold
			acc_nxt = acc_r - 7'h01;
		end
		ovl_trip_nxt = !ovl_cfg_r && (acc_r == `OVL_FULL);
		restrict_nxt = ovl_cfg_r && (acc_r == `OVL_FULL);
		ovl_evt      = ovl_trip_nxt && !overload_trip_out;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			acc_r                      <= 7'h00;
			overload_trip_out          <= 1'b0;
			current_limit_restrict_out <= 1'b0;
		end else begin
			acc_r                      <= acc_nxt;
			overload_trip_out          <= ovl_trip_nxt;
			current_limit_restrict_out <= restrict_nxt;
		end
	end

	// ==========================================================
	// Trip log and auto-reset sequencer
	trip_pkg::trip_evt_t    evt;
	trip_pkg::reset_state_t state_nxt;
	logic [7:0]  last_fault_nxt;
	logic [2:0]  cnt_nxt;
	logic [11:0] quiet_r, quiet_nxt;
	logic [7:0]  wait_r, wait_nxt;
	logic [7:0]  target_r, target_nxt;
	logic        active_nxt;
	logic        auto_nxt;
	logic        same;
	logic        is_oc;
	logic        allow;

	// Pin trips outrank internal ones when they coincide
	always_comb begin
		evt.valid = ext_rise || ovl_evt || trip_valid_in;
		evt.code  = ext_rise ? `CODE_EXTERNAL_FAULT_TRIP :
			ovl_evt ? `CODE_OVERLOAD_TIME_TRIP : trip_code_in;
	end

	always_comb begin
		state_nxt      = state_r;
		last_fault_nxt = last_fault_r;
		cnt_nxt        = cnt_r;
		quiet_nxt      = quiet_r;
		wait_nxt       = wait_r;
		target_nxt     = target_r;
		active_nxt     = trip_active_out;
		auto_nxt       = 1'b0;
		same  = evt.code == last_fault_r;
		is_oc = evt.code == `CODE_OUTPUT_STAGE_OVERCURRENT_TRIP ||
			evt.code == `CODE_BRAKING_STAGE_OVERCURRENT_TRIP;
		if (evt.valid) begin
			last_fault_nxt = evt.code;
			if (!same) begin
				cnt_nxt = 3'h0;
			end else if (cnt_r < limit_r) begin
				cnt_nxt = cnt_r + 3'h1;
			end
			allow = (limit_r != 3'h0) && (cnt_nxt < limit_r) &&
				(evt.code != `CODE_EXTERNAL_FAULT_TRIP);
			state_nxt  = allow ? trip_pkg::ST_WAIT : trip_pkg::ST_LOCKED;
			target_nxt = (is_oc && delay_r <= 8'(`OC_HOLD_TICKS)) ?
				8'(`OC_HOLD_TICKS + 1) : delay_r;
			wait_nxt   = 8'h00;
			quiet_nxt  = 12'h000;
			active_nxt = 1'b1;
		end else begin
			allow = 1'b0;
			if (fault_wr) begin
				last_fault_nxt = reg_wdata_in[7:0];
			end
			if (tick_r) begin
				if (quiet_r >= 12'(`QUIET_TICKS)) begin
					quiet_nxt = 12'h000;
					cnt_nxt   = 3'h0;
				end else begin
					quiet_nxt = quiet_r + 12'h001;
				end
			end
			if (sw_clear) begin
				state_nxt  = trip_pkg::ST_IDLE;
				active_nxt = 1'b0;
			end else if (state_r == trip_pkg::ST_WAIT) begin
				if (wait_r >= target_r) begin
					state_nxt  = trip_pkg::ST_IDLE;
					active_nxt = 1'b0;
					auto_nxt   = 1'b1;
				end else if (tick_r) begin
					wait_nxt = wait_r + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state_r         <= trip_pkg::ST_IDLE;
			last_fault_r    <= `RST_FAULT;
			cnt_r           <= 3'h0;
			quiet_r         <= 12'h000;
			wait_r          <= 8'h00;
			target_r        <= 8'h00;
			trip_active_out <= 1'b0;
			auto_reset_out  <= 1'b0;
		end else begin
			state_r         <= state_nxt;
			last_fault_r    <= last_fault_nxt;
			cnt_r           <= cnt_nxt;
			quiet_r         <= quiet_nxt;
			wait_r          <= wait_nxt;
			target_r        <= target_nxt;
			trip_active_out <= active_nxt;
			auto_reset_out  <= auto_nxt;
		end
	end

	// ==========================================================
	// Serial link mode
	trip_pkg::link_word_t tx_nxt;
	trip_pkg::link_word_t wr_nxt;

	always_comb begin
		tx_nxt.valid = (mode_r == `MODE_PARAM_OUT) && link_tx_ready_in;
		tx_nxt.data  = tx_nxt.valid ? param_value_in : link_tx_data_out;
		wr_nxt.valid = (mode_r == `MODE_PARAM_IN) && link_rx_valid_in;
		wr_nxt.data  = wr_nxt.valid ? link_rx_data_in : param_wdata_out;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			link_four_wire_out <= 1'b1;
			link_tx_valid_out  <= 1'b0;
			link_tx_data_out   <= 16'h0000;
			param_wr_out       <= 1'b0;
			param_wdata_out    <= 16'h0000;
			param_sel_out      <= `RST_POINTER;
		end else begin
			link_four_wire_out <= mode_r == `MODE_FOUR_WIRE;
			link_tx_valid_out  <= tx_nxt.valid;
			link_tx_data_out   <= tx_nxt.data;
			param_wr_out       <= wr_nxt.valid;
			param_wdata_out    <= wr_nxt.data;
			param_sel_out      <= ptr_r;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n);

	a_fault_logged: assert property (evt.valid |=>
		last_fault_r == $past(evt.code)) else $error("fault not logged");
	a_fault_holds: assert property (!evt.valid && !fault_wr |=>
		$stable(last_fault_r)) else $error("fault changed");
	a_zero_limit: assert property (evt.valid && limit_r == 3'h0 |=>
		state_r == trip_pkg::ST_LOCKED) else $error("reset at zero");
	a_reset_armed: assert property (evt.valid && allow |=>
		state_r == trip_pkg::ST_WAIT) else $error("reset not armed");
	a_count_clear: assert property (evt.valid && !same |=>
		cnt_r == 3'h0) else $error("count not cleared");
	a_limit_block: assert property (evt.valid && same &&
		cnt_r + 4'h1 >= {1'b0, limit_r} |=> state_r != trip_pkg::ST_WAIT)
		else $error("reset beyond limit");
	a_quiet_clear: assert property (tick_r && !evt.valid &&
		quiet_r == 12'(`QUIET_TICKS) |=> cnt_r == 3'h0)
		else $error("quiet clear missed");
	a_ext_locked: assert property (evt.valid &&
		evt.code == `CODE_EXTERNAL_FAULT_TRIP |=>
		state_r == trip_pkg::ST_LOCKED) else $error("external reset");
	a_delay_wait: assert property (state_r == trip_pkg::ST_WAIT &&
		wait_r < target_r |=> !auto_reset_out) else $error("early reset");
	a_oc_hold: assert property (evt.valid && is_oc |=>
		target_r > 8'(`OC_HOLD_TICKS)) else $error("short oc hold");
	a_mode_wire: assert property (##1 link_four_wire_out ==
		($past(mode_r) == `MODE_FOUR_WIRE)) else $error("wire mode");
	a_tx_forward: assert property (tx_nxt.valid |=> link_tx_valid_out &&
		link_tx_data_out == $past(param_value_in)) else $error("tx lost");
	a_rx_apply: assert property (wr_nxt.valid |=> param_wr_out &&
		param_wdata_out == $past(link_rx_data_in)) else $error("rx lost");
	a_ovl_rise: assert property (acc_r > $past(acc_r) |->
		$past(over)) else $error("rise without overload");
	a_ovl_full: assert property (acc_r == `OVL_FULL |=>
		overload_trip_out || current_limit_restrict_out)
		else $error("full without action");
	a_rated_clear: assert property (rated_change |=> acc_r == 7'h00)
		else $error("accumulator kept");
	a_quiet_restart: assert property (evt.valid |=> quiet_r == 12'h000)
		else $error("quiet not restarted");

	c_auto_reset: cover property (auto_reset_out);
	c_locked: cover property (state_r == trip_pkg::ST_LOCKED && cnt_r != 3'h0);
	c_ovl_trip: cover property ($rose(overload_trip_out));
	c_param_write: cover property (param_wr_out);

endmodule : trip_supervisor

/* File: tb/link_peer.sv */
// Peer drive on the serial link: offers transmit slots and sends words.
// Assumes the supervisor's link ports are registered on the same clock.
`timescale 1ns/1ps
module link_peer (
	input  wire logic        clk_in,
	input  wire logic        tx_valid_in,
	input  wire logic [15:0] tx_data_in,
	output logic             ready_out,
	output logic             rx_valid_out,
	output logic [15:0]      rx_data_out,
	output logic [15:0]      got_word_out,
	output logic [7:0]       got_count_out
);
	initial begin
		ready_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_data_out = 16'h0000;
		got_word_out = 16'h0000;
		got_count_out = 8'h00;
	end

	// ==========================================================
	// Capture of words that the drive transmits
	always @(posedge clk_in) begin
		if (tx_valid_in) begin
			got_word_out <= tx_data_in;
			got_count_out <= got_count_out + 8'h01;
		end
	end

	// ==========================================================
	// Link requests, one cycle each
	task offer_slot();
		@(posedge clk_in);
		ready_out <= 1'b1;
		@(posedge clk_in);
		ready_out <= 1'b0;
	endtask : offer_slot

	// Data is inverted once released so a stale word is never mistaken
	task send_word(input logic [15:0] d);
		@(posedge clk_in);
		rx_valid_out <= 1'b1;
		rx_data_out <= d;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_data_out <= ~d;
	endtask : send_word
endmodule : link_peer

/* File: tb/testbench.sv */
// Self-checking bench for the trip supervisor.
// Assumes a tick of 4 cycles so the long timers finish in simulation.
`timescale 1ns/1ps
`include "trip_params.svh"
module testbench;
	localparam int TK = 4;
	typedef struct {
		logic        wr;
		logic [3:0]  addr;
		logic [15:0] data;
		logic [15:0] exp;
	} row_t;
	logic        sys_clk_in, nrst_in, reg_wr_in, reg_rd_in, trip_valid_in;
	logic        ext_trip_pin_in, ready, rx_valid, trip_active_out;
	logic        auto_reset_out, overload_trip_out, restrict_out;
	logic        four_wire_out, tx_valid, param_wr_out;
	logic [3:0]  reg_addr_in;
	logic [7:0]  trip_code_in, got_count;
	logic [15:0] reg_wdata_in, reg_rdata_out, total_current_in, rx_data;
	logic [15:0] param_value_in, tx_data, param_sel_out, param_wdata_out;
	logic [15:0] got_word, st;
	int          fail_count, comparisons, n, t;
	row_t        rows [15] = '{
		'{0, `REG_LIMIT, 16'h0, 16'h0000}, '{0, `REG_DELAY, 16'h0, 16'h000a},
		'{0, `REG_MODE, 16'h0, 16'h0001}, '{0, `REG_RATED, 16'h0, 16'h0064},
		'{0, `REG_FAULT, 16'h0, 16'h0000}, '{0, `REG_OVL_LEVEL, 16'h0, 16'h0},
		'{1, `REG_LIMIT, 16'h0007, 16'h0005},
		'{1, `REG_DELAY, 16'h00ff, 16'h00fa},
		'{1, `REG_IGAIN, 16'h1234, 16'h1234},
		'{1, `REG_DCBUS, 16'h0abc, 16'h0abc},
		'{1, `REG_OVL_LEVEL, 16'h0055, 16'h0000},
		'{1, 4'hf, 16'h1111, 16'h0000},
		'{1, `REG_POINTER, 16'h0008, 16'h0008},
		'{1, `REG_MODE, 16'h0000, 16'h0000},
		'{1, `REG_FAULT, 16'h0011, 16'h0011}};

	trip_supervisor #(.TICK_CYCLES(TK)) trip_supervisor_inst (
		.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .trip_valid_in(trip_valid_in),
		.trip_code_in(trip_code_in), .ext_trip_pin_in(ext_trip_pin_in),
		.total_current_in(total_current_in),
		.param_value_in(param_value_in), .link_tx_ready_in(ready),
		.link_rx_valid_in(rx_valid), .link_rx_data_in(rx_data),
		.trip_active_out(trip_active_out), .auto_reset_out(auto_reset_out),
		.overload_trip_out(overload_trip_out),
		.current_limit_restrict_out(restrict_out),
		.link_four_wire_out(four_wire_out), .link_tx_valid_out(tx_valid),
		.link_tx_data_out(tx_data), .param_wr_out(param_wr_out),
		.param_sel_out(param_sel_out), .param_wdata_out(param_wdata_out));

	link_peer link_peer_inst (
		.clk_in(sys_clk_in), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
		.ready_out(ready), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
		.got_word_out(got_word), .got_count_out(got_count));

	// ==========================================================
	// Shared tasks
	task complete_run();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	task check(input string name, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask : check

	task reg_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask : reg_write

	// Read data is only valid in the single cycle after the strobe
	task reg_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#10;
		d = reg_rdata_out;
	endtask : reg_read

	task trip(input logic [7:0] c);
		@(posedge sys_clk_in);
		trip_valid_in <= 1'b1;
		trip_code_in <= c;
		@(posedge sys_clk_in);
		trip_valid_in <= 1'b0;
	endtask : trip

	// Returns max when no automatic reset pulse was seen
	task wait_reset(input int max, output int cnt);
		cnt = 0;
		while (cnt < max) begin
			@(posedge sys_clk_in);
			#10;
			if (auto_reset_out === 1'b1) break;
			cnt++;
		end
	endtask : wait_reset

	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	initial begin
		#(40000 * 100);
		fail_count++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{nrst_in, reg_wr_in, reg_rd_in, trip_valid_in, ext_trip_pin_in} = 0;
		{reg_addr_in, trip_code_in, reg_wdata_in} = 0;
		{total_current_in, param_value_in} = 0;
		fail_count = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		check("four_wire", 16'h1, {15'h0, four_wire_out});
		foreach (rows[i]) begin
			if (rows[i].wr) reg_write(rows[i].addr, rows[i].data);
			reg_read(rows[i].addr, st);
			check("reg", rows[i].exp, st);
		end
		// Limit zero: the trip stays latched
		reg_write(`REG_LIMIT, 16'h0000);
		reg_write(`REG_DELAY, 16'h0000);
		trip(8'h22);
		wait_reset(20, n);
		check("no_reset", 16'd20, 16'(n));
		reg_read(`REG_STATUS, st);
		check("locked", 16'h0005, st & 16'h0007);
		check("active", 16'h1, {15'h0, trip_active_out});
		reg_read(`REG_FAULT, st);
		check("fault", 16'h0022, st);
		reg_write(`REG_STATUS, 16'h0001);
		// Same code counts up to the limit, then locks
		reg_write(`REG_LIMIT, 16'h0002);
		trip(8'h22);
		wait_reset(20, n);
		check("auto_reset", 16'h1, {15'h0, n <= 3});
		trip(8'h22);
		wait_reset(20, n);
		check("limit_lock", 16'd20, 16'(n));
		reg_read(`REG_STATUS, st);
		check("count", 16'h0015, st & 16'h003f);
		reg_write(`REG_STATUS, 16'h0001);
		repeat (3000 * TK + 100) @(posedge sys_clk_in);
		reg_read(`REG_STATUS, st);
		check("quiet", 16'h0000, st & 16'h0038);
		trip(8'h22);
		wait_reset(20, n);
		check("after_quiet", 16'h1, {15'h0, n <= 3});
		trip(8'h33);
		wait_reset(20, n);
		check("new_code", 16'h1, {15'h0, n <= 3});
		reg_read(`REG_STATUS, st);
		check("count_clr", 16'h0000, st & 16'h0039);
		reg_read(`REG_FAULT, st);
		check("fault_hold", 16'h0033, st);
		// External trip never resets itself
		reg_write(`REG_LIMIT, 16'h0005);
		@(posedge sys_clk_in);
		ext_trip_pin_in <= 1'b1;
		wait_reset(60, n);
		check("ext_reset", 16'd60, 16'(n));
		reg_read(`REG_FAULT, st);
		check("ext_code", {8'h0, `CODE_EXTERNAL_FAULT_TRIP}, st);
		reg_write(`REG_STATUS, 16'h0001);
		ext_trip_pin_in <= 1'b0;
		// Programmed delay, and the long hold for over-current codes
		for (int k = 0; k < 3; k++) begin
			reg_write(`REG_DELAY, (k == 0) ? 16'h0003 : 16'h0000);
			trip((k == 0) ? 8'h44 : (k == 1) ?
				`CODE_OUTPUT_STAGE_OVERCURRENT_TRIP :
				`CODE_BRAKING_STAGE_OVERCURRENT_TRIP);
			t = (k == 0) ? 3 : `OC_HOLD_TICKS;
			wait_reset(500, n);
			// Over-current holds may not end a tick short of ten seconds
			check("delay", 16'h1, {15'h0, n <= t*TK+4 &&
				n >= ((k == 0) ? (t-1)*TK : t*TK+1)});
		end
		// Overload accumulator
		reg_write(`REG_LIMIT, 16'h0000);
		total_current_in <= 16'd105;
		repeat (30 * TK) @(posedge sys_clk_in);
		reg_read(`REG_OVL_LEVEL, st);
		check("ovl_105", 16'h0000, st);
		total_current_in <= 16'd106;
		repeat (105 * TK) @(posedge sys_clk_in);
		reg_read(`REG_OVL_LEVEL, st);
		check("ovl_full", 16'h0064, st);
		check("ovl_trip", 16'h1, {15'h0, overload_trip_out});
		reg_read(`REG_FAULT, st);
		check("ovl_code", {8'h0, `CODE_OVERLOAD_TIME_TRIP}, st);
		total_current_in <= 16'd0;
		reg_write(`REG_RATED, 16'h00c8);
		reg_read(`REG_OVL_LEVEL, st);
		check("ovl_clear", 16'h0000, st);
		reg_write(`REG_OVL_CFG, 16'h0001);
		reg_write(`REG_STATUS, 16'h0001);
		total_current_in <= 16'd211;
		repeat (105 * TK) @(posedge sys_clk_in);
		check("restrict", 16'h1, {15'h0, restrict_out});
		check("no_ovl_trip", 16'h0, {15'h0, overload_trip_out});
		total_current_in <= 16'd0;
		// Link modes
		for (int m = 0; m < 4; m++) begin
			reg_write(`REG_MODE, 16'(m));
			repeat (2) @(posedge sys_clk_in);
			check("four_wire", {15'h0, m == 1}, {15'h0, four_wire_out});
		end
		link_peer_inst.offer_slot();
		link_peer_inst.send_word(16'h1357);
		#10;
		check("param_wr", 16'h1, {15'h0, param_wr_out});
		check("param_data", 16'h1357, param_wdata_out);
		check("param_sel", 16'h0008, param_sel_out);
		check("no_tx", 16'h0, {8'h0, got_count});
		reg_write(`REG_MODE, 16'h0002);
		param_value_in <= 16'hbeef;
		link_peer_inst.offer_slot();
		repeat (3) @(posedge sys_clk_in);
		check("tx_word", 16'hbeef, got_word);
		check("tx_count", 16'h0001, {8'h0, got_count});
		// Mid-run reset returns the settings to their defaults
		nrst_in <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
		#10;
		check("rst_wire", 16'h1, {15'h0, four_wire_out});
		check("rst_active", 16'h0, {15'h0, trip_active_out});
		nrst_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		reg_read(`REG_MODE, st);
		check("rst_mode", 16'h0001, st);
		reg_read(`REG_DELAY, st);
		check("rst_delay", 16'h000a, st);
		complete_run();
	end
endmodule : testbench
